// ---- include/ptc_regs.vh ----
// Functional notes
// - Function select in timer mode picks pulse width
// - Wide mode joins both timers into one counter
// - Polarity 0 measures low, 1 measures high
// - Prescaled clock gated by selected input level
// - Underflow sets own flag, raises request
// - Per-timer enable blocks its interrupt request
// - Per-timer priority field, levels 0 to 3
// - Timer 1 vectors 000006h, timer 0 000008h
// - Wide mode: timer 0 flag never set
// - Clock output toggles on each selected underflow
// - Source select 0 timer 0, 1 timer 1
// - Wide mode forces combined underflow as source
// - Enable 1 outputs clock, 0 drives high
// - Output enable gating asynchronous to toggle
// - Timer 1 underflow feeds serial clock, divided 32
// - Underflow reloads counter, drives its flag (not timer 0 in wide mode), the clock output if selected, and (timer 1) the serial clock
`ifndef PTC_REGS_VH
`define PTC_REGS_VH
`define PTC_ADDR_CTRL     4'h0
`define PTC_ADDR_T0CFG    4'h1
`define PTC_ADDR_T1CFG    4'h2
`define PTC_ADDR_RELOAD   4'h3
`define PTC_ADDR_COUNT    4'h4
`define PTC_ADDR_IRQ_STAT 4'h5
`define PTC_ADDR_IRQ_MASK 4'h6
`define PTC_ADDR_IRQ_PRIO 4'h7
`define PTC_ADDR_VECTOR   4'h8
`define PTC_CTRL_WIDE     4
`define PTC_CTRL_CHSRC    3
`define PTC_CTRL_OUTEN    2
`define PTC_CFG_CNTMODE   7
`define PTC_CFG_FUNC      6
`define PTC_CFG_POL       5
`define PTC_CFG_PSC_HI    4
`define PTC_CFG_PSC_LO    3
`define PTC_CFG_CONT      2
`define PTC_CFG_PRESET    1
`define PTC_CFG_RUN       0
`define PTC_VEC_T1        24'h000006
`define PTC_VEC_T0        24'h000008
`define PTC_SER_DIV       5'h1f
`define PTC_RESP_OKAY     2'h0
`define PTC_RESP_SLVERR   2'h2
`endif

// ---- rtl/ptc_timer.v ----
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "ptc_regs.vh"
module ptc_timer (
  input  wire        i_clock,           // System clock, 100 MHz
  input  wire        i_reset_n,         // Async reset, active low
  input  wire [5:0]  i_awaddr,          // Write address
  input  wire        i_awvalid,         // Write address valid
  output wire        o_awready,         // Write address ready
  input  wire [31:0] i_wdata,           // Write data
  input  wire [3:0]  i_wstrb,           // Write strobes
  input  wire        i_wvalid,          // Write data valid
  output wire        o_wready,          // Write data ready
  output reg  [1:0]  o_bresp,           // Write response
  output reg         o_bvalid,          // Write response valid
  input  wire        i_bready,          // Write response ready
  input  wire [5:0]  i_araddr,          // Read address
  input  wire        i_arvalid,         // Read address valid
  output wire        o_arready,         // Read address ready
  output reg  [31:0] o_rdata,           // Read data
  output reg  [1:0]  o_rresp,           // Read response
  output reg         o_rvalid,          // Read data valid
  input  wire        i_rready,          // Read data ready
  input  wire        i_input_port_pin,  // External level input, async
  input  wire        i_osc_tick,        // Source clock enable pulse
  output wire        o_output_port_pin, // Clock output pin
  output wire        o_serial_clock,    // Serial bit clock pulse
  output wire        o_irq,             // Interrupt request level
  output wire [1:0]  o_irq_level,       // Priority of pending request
  output wire [23:0] o_irq_vector       // Vector of pending request
);
  reg  [7:0]  ctrl_r;
  reg  [7:0]  cfg_r [0:1];
  reg  [7:0]  reload_r [0:1];
  reg  [7:0]  count_r [0:1];
  reg  [1:0]  stat_r;
  reg  [1:0]  mask_r;
  reg  [3:0]  prio_r;
  reg  [5:0]  psc_div_r [0:1];
  reg  [2:0]  pin_sync_r;
  reg         pin_level_r;
  reg         timer_clock_output_r;
  reg  [4:0]  ser_cnt_r;
  reg         ser_clk_r;
  reg         aw_got_r;
  reg         w_got_r;
  reg  [5:0]  aw_addr_r;
  reg  [31:0] w_data_r;
  reg  [3:0]  w_strb_r;
  wire        wide;
  wire [1:0]  tick;
  wire [1:0]  underflow;
  wire        sel_uf;
  wire        wr_fire;
  wire        wr_hit;
  wire [3:0]  wr_idx;
  wire [3:0]  rd_idx;
  wire [7:0]  wbyte;
  wire [1:0]  pend;
  reg  [7:0]  rd_val;
  reg  [1:0]  stat_nxt;
  wire [1:0]  stat_set;
  reg         timer_clock_output_nxt;
  reg  [4:0]  ser_cnt_nxt;
  reg         ser_clk_nxt;
  integer     k;

  // Prescaler length for a two-bit divide code
  function [5:0] ptc_psc_max;
    input [1:0] code;
    begin
      case (code)
        2'h0:    ptc_psc_max = 6'h00;
        2'h1:    ptc_psc_max = 6'h03;
        2'h2:    ptc_psc_max = 6'h0f;
        default: ptc_psc_max = 6'h3f;
      endcase
    end
  endfunction

  // Register index inside the decoded window
  function ptc_mapped;
    input [3:0] idx;
    begin
      ptc_mapped = (idx <= `PTC_ADDR_VECTOR);
    end
  endfunction

  // Register words, byte address is index times four:
  //   0 control: wide mode, output source, output enable
  //   1 timer 0 setup: mode, function, polarity, divide, run
  //   2 timer 1 setup: divide, continuous, preset, run
  //   3 reload values, timer 0 low byte, timer 1 high byte
  //   4 live counts, read only
  //   5 sticky flags, write one to clear
  //   6 flag enables
  //   7 priority levels, timer 0 low pair, timer 1 high pair
  //   8 vector of the pending request, read only
  // Only byte lane 0 writes, except the reload word.
  // Unknown indices answer with a slave error.
  // Preset bits are write only and read back as zero.
  // In wide mode timer 1 setup is ignored but for its preset, and its run bit
  // is held low; timer 0 setup steers the joined counter.

  // Wide mode chains timer 1 behind timer 0
  assign wide = ctrl_r[`PTC_CTRL_WIDE];

  // Pin sampled through three stages
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pin_sync_r  <= 3'h0;
      pin_level_r <= 1'b0;
    end else begin
      pin_sync_r <= {pin_sync_r[1:0], i_input_port_pin};
      if (pin_sync_r[1] == pin_sync_r[2])
        pin_level_r <= pin_sync_r[2];
    end
  end

  // Per-timer prescaler and count enable.
  // Pulse width gating only stops the prescaled tick, so
  // the count and reload behave as in plain timer mode.
  // In wide mode timer 1 ticks when timer 0 underflows,
  // which makes the pair one sixteen-bit down counter.
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_tmr
      wire [7:0] cf = (wide && g == 1) ? cfg_r[0] : cfg_r[g];
      wire       run = (wide && g == 1) ? cfg_r[0][`PTC_CFG_RUN] : cfg_r[g][`PTC_CFG_RUN];
      wire       psc_tick = run && i_osc_tick && (psc_div_r[g] == ptc_psc_max(cf[4:3]));
      wire       pw_gate = (g == 1 && !wide) || !cf[`PTC_CFG_FUNC] || cf[`PTC_CFG_CNTMODE] ||
                           (pin_level_r == cf[`PTC_CFG_POL]);
      wire       t0_tick = psc_tick && pw_gate;
      assign tick[g] = (g == 1 && wide) ? (tick[0] && count_r[0] == 8'h00) : t0_tick;
      assign underflow[g] = tick[g] && count_r[g] == 8'h00;
    end
  endgenerate

  assign sel_uf = wide ? underflow[1] : underflow[ctrl_r[`PTC_CTRL_CHSRC]];

  // Counters, prescalers and run control.
  // One-shot timers drop their run bit on underflow;
  // a preset copies the reload value into the counter.
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (k = 0; k < 2; k = k + 1) begin
        cfg_r[k]     <= 8'h00;
        reload_r[k]  <= 8'h00;
        count_r[k]   <= 8'h00;
        psc_div_r[k] <= 6'h00;
      end
      ctrl_r <= 8'h00;
      prio_r <= 4'h0;
      mask_r <= 2'h0;
    end else begin
      for (k = 0; k < 2; k = k + 1) begin
        if (i_osc_tick && cfg_r[k][`PTC_CFG_RUN])
          psc_div_r[k] <= (psc_div_r[k] == ptc_psc_max(cfg_r[k][4:3])) ? 6'h00
                          : psc_div_r[k] + 6'h01;
        if (underflow[k])
          count_r[k] <= reload_r[k];
        else if (tick[k])
          count_r[k] <= count_r[k] - 8'h01;
        if (underflow[k] && !cfg_r[k][`PTC_CFG_CONT] && !(wide && k == 0))
          cfg_r[k][`PTC_CFG_RUN] <= 1'b0;
      end
      if (wide && underflow[1] && !cfg_r[0][`PTC_CFG_CONT])
        cfg_r[0][`PTC_CFG_RUN] <= 1'b0;
      if (wide)
        cfg_r[1][`PTC_CFG_RUN] <= 1'b0;
      cfg_r[0][`PTC_CFG_PRESET] <= 1'b0;
      cfg_r[1][`PTC_CFG_PRESET] <= 1'b0;
      if (wr_fire && wr_hit && w_strb_r[0]) begin
        case (wr_idx)
          `PTC_ADDR_CTRL:     ctrl_r <= {3'h0, wbyte[4:0]};
          `PTC_ADDR_T0CFG:    cfg_r[0] <= wbyte;
          `PTC_ADDR_T1CFG:    cfg_r[1] <= {3'h0, wbyte[4:0]};
          `PTC_ADDR_RELOAD:   {reload_r[1], reload_r[0]} <= w_data_r[15:0];
          `PTC_ADDR_IRQ_MASK: mask_r <= wbyte[1:0];
          `PTC_ADDR_IRQ_PRIO: prio_r <= wbyte[3:0];
          default: ;
        endcase
        if (wr_idx == `PTC_ADDR_T0CFG && wbyte[`PTC_CFG_PRESET])
          count_r[0] <= reload_r[0];
        if (wr_idx == `PTC_ADDR_T1CFG && wbyte[`PTC_CFG_PRESET])
          count_r[1] <= reload_r[1];
      end
    end
  end

  // Underflow events; wide mode never flags timer 0
  assign stat_set = {underflow[1], underflow[0] && !wide};

  // Next flags, a same-cycle event beats the clear
  always @* begin
    stat_nxt = stat_r;
    if (wr_fire && wr_hit && w_strb_r[0] && wr_idx == `PTC_ADDR_IRQ_STAT)
      stat_nxt = stat_r & ~wbyte[1:0];
    stat_nxt = stat_nxt | stat_set;
  end

  // Sticky flags
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      stat_r <= 2'h0;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  // Request level, priority and vector of the pending flag.
  // Timer 1 wins when both are pending, as its vector is lower.

  assign pend = stat_r & mask_r;
  assign o_irq = |pend;
  assign o_irq_level = pend[1] ? prio_r[3:2] : prio_r[1:0];
  assign o_irq_vector = pend[1] ? `PTC_VEC_T1 : (pend[0] ? `PTC_VEC_T0 : 24'h000000);

  // Next toggle and serial divider state
  always @* begin
    timer_clock_output_nxt    = timer_clock_output_r;
    ser_cnt_nxt = ser_cnt_r;
    ser_clk_nxt = underflow[1] && ser_cnt_r == `PTC_SER_DIV;
    if (sel_uf)
      timer_clock_output_nxt = ~timer_clock_output_r;
    if (underflow[1])
      ser_cnt_nxt = ser_cnt_r + 5'h01;
  end

  // Clock output toggle and serial divider.
  // The serial side sees one pulse per 32 timer 1 underflows.
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      timer_clock_output_r    <= 1'b0;
      ser_cnt_r <= 5'h00;
      ser_clk_r <= 1'b0;
    end else begin
      timer_clock_output_r    <= timer_clock_output_nxt;
      ser_cnt_r <= ser_cnt_nxt;
      ser_clk_r <= ser_clk_nxt;
    end
  end

  assign o_serial_clock = ser_clk_r;
  // Gating not resynchronised to the toggle, so edges may glitch
  assign o_output_port_pin = ctrl_r[`PTC_CTRL_OUTEN] ? timer_clock_output_r : 1'b1;

  // AXI write channel capture.
  // Address and data are held apart until both have arrived;
  // neither channel is taken again while a response waits.
  assign o_awready = !aw_got_r && !o_bvalid;
  assign o_wready  = !w_got_r && !o_bvalid;
  assign wr_fire   = aw_got_r && w_got_r && !o_bvalid;
  assign wr_idx    = aw_addr_r[5:2];
  assign wr_hit    = ptc_mapped(wr_idx);
  assign wbyte     = w_data_r[7:0];
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      aw_addr_r <= 6'h00;
      w_data_r  <= 32'h0;
      w_strb_r  <= 4'h0;
      o_bvalid  <= 1'b0;
      o_bresp   <= 2'h0;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_got_r  <= 1'b1;
        aw_addr_r <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_got_r  <= 1'b1;
        w_data_r <= i_wdata;
        w_strb_r <= i_wstrb;
      end
      if (wr_fire) begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp  <= wr_hit ? `PTC_RESP_OKAY : `PTC_RESP_SLVERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // Read mux for the byte-wide registers
  assign rd_idx = i_araddr[5:2];
  always @* begin
    case (rd_idx)
      `PTC_ADDR_CTRL:     rd_val = {3'h0, ctrl_r[4:0]};
      `PTC_ADDR_T0CFG:    rd_val = cfg_r[0] & 8'hfd;
      `PTC_ADDR_T1CFG:    rd_val = cfg_r[1] & 8'h1d;
      `PTC_ADDR_COUNT:    rd_val = count_r[0];
      `PTC_ADDR_IRQ_STAT: rd_val = {6'h00, stat_r};
      `PTC_ADDR_IRQ_MASK: rd_val = {6'h00, mask_r};
      `PTC_ADDR_IRQ_PRIO: rd_val = {4'h0, prio_r};
      default:            rd_val = 8'h00;
    endcase
  end

  assign o_arready = !o_rvalid;
  // Read response, one cycle after address.
  // Data is latched with the address, so it holds while waiting.
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rvalid <= 1'b0;
      o_rdata  <= 32'h0;
      o_rresp  <= 2'h0;
    end else if (i_arvalid && o_arready) begin
      o_rvalid <= 1'b1;
      o_rresp  <= ptc_mapped(rd_idx) ? `PTC_RESP_OKAY : `PTC_RESP_SLVERR;
      if (rd_idx == `PTC_ADDR_RELOAD)
        o_rdata <= {16'h0, reload_r[1], reload_r[0]};
      else if (rd_idx == `PTC_ADDR_COUNT)
        o_rdata <= {16'h0, count_r[1], count_r[0]};
      else if (rd_idx == `PTC_ADDR_VECTOR)
        o_rdata <= {8'h00, o_irq_vector};
      else
        o_rdata <= {24'h0, rd_val};
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/ptc_timer_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none
module ptc_timer_monitor (
  input wire logic        i_clock,           // Clock
  input wire logic        i_reset_n,         // Reset
  input wire logic        i_arvalid,         // Read request
  input wire logic        i_bready,          // Write resp ready
  input wire logic        i_rready,          // Read resp ready
  input wire logic        o_awready,         // Write addr ready
  input wire logic        o_arready,         // Read addr ready
  input wire logic        o_bvalid,          // Write resp
  input wire logic        o_rvalid,          // Read resp
  input wire logic [31:0] o_rdata,           // Read data
  input wire logic        o_output_port_pin, // Clock pin
  input wire logic        o_serial_clock,    // Serial pulse
  input wire logic        o_irq,             // Interrupt
  input wire logic [23:0] o_irq_vector       // Vector
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  // Bus handshake holds
  property p_bhold; o_bvalid && !i_bready |=> o_bvalid; endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped");
  property p_rhold; o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read answer changed");
  property p_awblk; o_bvalid |-> !o_awready; endproperty
  a_awblk: assert property (p_awblk) else $error("write taken during response");
  property p_arblk; o_rvalid |-> !o_arready; endproperty
  a_arblk: assert property (p_arblk) else $error("read taken during response");
  property p_rans; i_arvalid && o_arready |=> o_rvalid; endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
  // Vector, pulse shape and reset outputs
  property p_vec; o_irq |-> o_irq_vector == 24'h000006 || o_irq_vector == 24'h000008; endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_ser; o_serial_clock |=> !o_serial_clock [*8]; endproperty
  a_ser: assert property (p_ser) else $error("serial pulse too dense");
  property p_rst; $rose(i_reset_n) |-> o_output_port_pin && !o_irq; endproperty
  a_rst: assert property (p_rst) else $error("bad reset outputs");
  c_irq: cover property (o_irq);
  c_ser: cover property (o_serial_clock);
  c_pin: cover property ($fell(o_output_port_pin));
endmodule
bind ptc_timer ptc_timer_monitor u_mon (.i_clock, .i_reset_n, .i_arvalid, .i_bready,
  .i_rready, .o_awready, .o_arready, .o_bvalid, .o_rvalid, .o_rdata,
  .o_output_port_pin, .o_serial_clock, .o_irq, .o_irq_vector);
`default_nettype wire

// ---- testbench/ptc_pulse_src.sv ----
`timescale 1ns/1ns
`default_nettype none
module ptc_pulse_src (
  input  wire logic i_clock,        // Clock
  input  wire logic i_level,        // Requested pin level
  input  wire logic i_serial_clock, // Serial pulse
  output var logic  o_pin,          // External level pin
  output var logic  o_tick,         // Source clock pulse
  output var int    o_sers          // Serial pulses seen
);
  initial o_tick = 1'b0;
  initial o_pin = 1'b0;
  initial o_sers = 0;
  // Source ticks every other cycle, pin follows request
  always @(posedge i_clock) begin
    o_tick <= ~o_tick;
    o_pin <= i_level;
  end
  // Serial side counts bit clock pulses
  always @(posedge i_clock) begin
    if (i_serial_clock === 1'b1) o_sers <= o_sers + 1;
  end
endmodule
`default_nettype wire

// ---- testbench/ptc_timer_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "ptc_regs.vh"
module ptc_timer_tb;
  reg i_clock = 0, i_reset_n = 0, i_awvalid = 0, i_wvalid = 0, i_bready = 0;
  reg i_arvalid = 0, i_rready = 0, lvl = 0, pq = 1;
  reg [5:0] i_awaddr = 0, i_araddr = 0;
  reg [31:0] i_wdata = 0, d, c;
  reg [1:0] rsp;
  wire aw_rdy, w_rdy, bv, ar_rdy, rv, pin, ser, irq, tick, ext;
  wire [1:0] bresp, rresp, lev;
  wire [31:0] rdata;
  wire [23:0] vec;
  int sers;
  integer fails = 0, checked = 0, cyc = 0, togs = 0, k;
  ptc_timer DUT (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_awaddr(i_awaddr),
    .i_awvalid(i_awvalid), .o_awready(aw_rdy), .i_wdata(i_wdata), .i_wstrb(4'hf),
    .i_wvalid(i_wvalid), .o_wready(w_rdy), .o_bresp(bresp), .o_bvalid(bv),
    .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
    .o_arready(ar_rdy), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rv),
    .i_rready(i_rready), .i_input_port_pin(ext), .i_osc_tick(tick),
    .o_output_port_pin(pin), .o_serial_clock(ser), .o_irq(irq),
    .o_irq_level(lev), .o_irq_vector(vec));
  ptc_pulse_src u_src (.i_clock(i_clock), .i_level(lvl), .i_serial_clock(ser),
    .o_pin(ext), .o_tick(tick), .o_sers(sers));
  always #5 i_clock = ~i_clock;
  // Pin toggle counter and run limit
  always @(posedge i_clock) begin
    pq <= pin;
    if (pq !== pin) togs <= togs + 1;
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails = fails + 1;
      stop_test;
    end
  end
  task wr(input [3:0] a, input [31:0] v);
    begin
      i_awaddr <= {a, 2'b00};
      i_wdata <= v;
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      i_bready <= 1'b1;
      do begin
        @(posedge i_clock);
        if (i_awvalid && aw_rdy) i_awvalid <= 1'b0;
        if (i_wvalid && w_rdy) i_wvalid <= 1'b0;
        if (i_bready && bv) begin
          i_bready <= 1'b0;
          rsp = bresp;
        end
      end while (i_awvalid || i_wvalid || i_bready);
    end
  endtask
  task rd(input [3:0] a);
    begin
      i_araddr <= {a, 2'b00};
      i_arvalid <= 1'b1;
      i_rready <= 1'b1;
      do begin
        @(posedge i_clock);
        if (i_arvalid && ar_rdy) i_arvalid <= 1'b0;
        if (i_rready && rv) begin
          i_rready <= 1'b0;
          d = rdata;
          rsp = rresp;
        end
      end while (i_arvalid || i_rready);
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      checked = checked + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task wt(input integer n);
    repeat (n) @(posedge i_clock);
  endtask
  task wirq;
    for (k = 0; k < 600 && irq !== 1'b1; k = k + 1) @(posedge i_clock);
  endtask
  task stop_test;
    begin
      $display("checked=%0d fails=%0d", checked, fails);
      if (fails == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial begin
    wt(3);
    i_reset_n <= 1'b1;
    // Reset state and unmapped place
    rd(`PTC_ADDR_CTRL);
    chk(d, 0);
    rd(4'h9);
    chk(rsp, `PTC_RESP_SLVERR);
    wr(4'h9, 32'h0);
    chk(rsp, `PTC_RESP_SLVERR);
    chk(pin, 1);
    $display("reset done");
    // Counting gated by pin level, both polarities
    wr(`PTC_ADDR_RELOAD, 32'h40);
    chk(rsp, `PTC_RESP_OKAY);
    wr(`PTC_ADDR_T0CFG, 32'h67);
    wt(20);
    rd(`PTC_ADDR_COUNT);
    chk(d[7:0], 8'h40);
    lvl <= 1'b1;
    wt(30);
    rd(`PTC_ADDR_COUNT);
    chk(d[7:0] < 8'h40, 1);
    wr(`PTC_ADDR_T0CFG, 32'h45);
    rd(`PTC_ADDR_COUNT);
    c = d;
    wt(20);
    rd(`PTC_ADDR_COUNT);
    chk(d[7:0], c[7:0]);
    $display("pulse width done");
    // Timer 0 interrupt: masked, then enabled
    wr(`PTC_ADDR_T0CFG, 32'h65);
    wt(300);
    rd(`PTC_ADDR_IRQ_STAT);
    chk(d[0], 1);
    chk(irq, 0);
    wr(`PTC_ADDR_IRQ_MASK, 32'h1);
    wr(`PTC_ADDR_IRQ_PRIO, 32'h3);
    wt(2);
    chk(irq, 1);
    chk(vec, `PTC_VEC_T0);
    chk(lev, 3);
    wr(`PTC_ADDR_T0CFG, 32'h0);
    wr(`PTC_ADDR_IRQ_STAT, 32'h1);
    wt(2);
    chk(irq, 0);
    // Timer 1 interrupt and clock output from it
    wr(`PTC_ADDR_CTRL, 32'h0c);
    wr(`PTC_ADDR_T1CFG, 32'h05);
    wr(`PTC_ADDR_IRQ_MASK, 32'h2);
    wr(`PTC_ADDR_IRQ_PRIO, 32'h8);
    togs = 0;
    wirq;
    chk(vec, `PTC_VEC_T1);
    chk(lev, 2);
    wt(300);
    chk(togs > 0, 1);
    wr(`PTC_ADDR_CTRL, 32'h04);
    wt(4);
    togs = 0;
    wt(300);
    chk(togs, 0);
    wr(`PTC_ADDR_CTRL, 32'h08);
    wt(4);
    togs = 0;
    wt(300);
    chk(togs, 0);
    chk(pin, 1);
    $display("interrupt and clock out done");
    // Serial clock from fast timer 1 underflow
    wr(`PTC_ADDR_RELOAD, 32'h0);
    wr(`PTC_ADDR_T1CFG, 32'h07);
    c = sers;
    wt(640);
    chk((sers - c) >= 4 && (sers - c) <= 20, 1);
    wr(`PTC_ADDR_T1CFG, 32'h0);
    wr(`PTC_ADDR_IRQ_STAT, 32'h3);
    $display("serial done");
    // Wide mode: combined flag and clock source
    wr(`PTC_ADDR_CTRL, 32'h14);
    wr(`PTC_ADDR_RELOAD, 32'h2);
    wr(`PTC_ADDR_T0CFG, 32'h07);
    togs = 0;
    wt(300);
    rd(`PTC_ADDR_IRQ_STAT);
    chk(d[1:0], 2'h2);
    chk(togs > 0, 1);
    $display("wide done");
    stop_test;
  end
endmodule
`default_nettype wire
